// ---- design/fsd_decoder.sv ----
`timescale 1ns/1ps
module fsd_decoder (
    input  wire logic        CORE_CLK,
    input  wire logic        SYS_RST,
    input  wire logic        CLK_EN,
    input  wire logic        RX_VALID,
    input  wire logic [7:0]  RX_BYTE,
    output logic             DISP_VALID,
    output logic [15:0]      DISP_ID,
    output logic [1:0]       DISP_CLASS,
    output logic [7:0]       DISP_LEN,
    output logic [7:0]       DISP_ARG0,
    output logic             DISP_DROP,
    input  wire logic        DONE,
    input  wire logic [7:0]  DONE_CODE,
    input  wire logic        EVT_VALID,
    input  wire logic [7:0]  EVT_CODE,
    output logic             EVT_READY,
    output logic             TX_VALID,
    output logic [7:0]       TX_BYTE,
    input  wire logic        TX_READY,
    output logic [7:0]       BCN_TMO_S,
    output logic [7:0]       PAIR_TMO_S,
    output logic [7:0]       LINK_RF,
    output logic             REM_CREATE_EN,
    output logic             BCN_OPEN
);
    typedef enum logic [2:0] {
        FSD_RX_SYNC, FSD_RX_LEN, FSD_RX_IDH, FSD_RX_IDL, FSD_RX_DATA, FSD_RX_SUM
    } fsd_rx_t;
    typedef enum logic [2:0] {
        FSD_EX_IDLE, FSD_EX_FETCH, FSD_EX_BUSY, FSD_EX_TX
    } fsd_ex_t;

    typedef struct packed {
        fsd_rx_t     rx;
        fsd_ex_t     ex;
        logic [7:0]  len;
        logic [7:0]  cnt;
        logic [7:0]  sum;
        logic [15:0] id;
        logic [7:0]  arg0;
        logic        disp_v;
        logic        drop;
        logic [15:0] tx_id;
        logic [7:0]  tx_code;
        logic [2:0]  tx_idx;
        logic [7:0]  tx_sum;
        logic [7:0]  tx_byte;
        logic        evt_rdy;
        logic [7:0]  bcn_tmo;
        logic [7:0]  pair_tmo;
        logic [7:0]  link_rf;
        logic        rem_create;
        logic        bcn_open;
        logic [1:0]  cls;
    } fsd_state_t;

    fsd_state_t s_q;
    fsd_state_t s_d;
    logic       rx_v_m;
    logic       rx_v_s;
    logic [7:0] rx_b_m;
    logic [7:0] rx_b_s;

    fsd_pay_if pay ();

    fsd_pay_mem u_pay (
        .clk (CORE_CLK),
        .ce  (CLK_EN),
        .pay (pay)
    );

    // Classify an identifier; unknown ones give NONE
    function automatic logic [1:0] id_class(input logic [15:0] id);
        logic [1:0] c;
        c = 2'h0;
        if (id[15:13] != fsd_pkg::EXT_PREFIX[7:5]) begin    // R2
            c = 2'h0;
        end else begin
            case (id)
                fsd_pkg::ID_EEPROM_INIT, fsd_pkg::ID_FS_INIT,      // R3 R4
                fsd_pkg::ID_FORMAT, fsd_pkg::ID_DIR_SAVE,          // R5
                fsd_pkg::ID_DIR_COMPACT, fsd_pkg::ID_FILE_DELETE,  // R6 R7
                fsd_pkg::ID_FILE_CLOSE, fsd_pkg::ID_SET_FLAGS,     // R8
                fsd_pkg::ID_KEY_ADD, fsd_pkg::ID_KEY_SELECT,       // R19
                fsd_pkg::ID_KEY_DIRECT, fsd_pkg::ID_BCN_OPEN,
                fsd_pkg::ID_BCN_CLOSE, fsd_pkg::ID_BCN_SETUP,
                fsd_pkg::ID_AUTH_STR, fsd_pkg::ID_BCN_STATE,
                fsd_pkg::ID_PAIR_ANSWER, fsd_pkg::ID_LINK_RF,      // R20 R21
                fsd_pkg::ID_BCN_TMO, fsd_pkg::ID_PAIR_TMO,         // R25
                fsd_pkg::ID_REM_CREATE: c = 2'h1;
                fsd_pkg::ID_USED_SPACE, fsd_pkg::ID_FREE_SPACE,    // R9 R10
                fsd_pkg::ID_FIND_INDEX, fsd_pkg::ID_DIR_RD_ABS,    // R11 R12
                fsd_pkg::ID_DIR_RD_ENT, fsd_pkg::ID_DIR_SIZE,      // R13
                fsd_pkg::ID_FILE_ALLOC, fsd_pkg::ID_FILE_OPEN,     // R14 R15
                fsd_pkg::ID_RD_ABS, fsd_pkg::ID_RD_PTR,            // R16
                fsd_pkg::ID_WR_ABS, fsd_pkg::ID_WR_PTR,            // R17
                fsd_pkg::ID_FILE_SIZE, fsd_pkg::ID_FILE_FLAGS,     // R18
                fsd_pkg::ID_PIPE_FETCH, fsd_pkg::ID_PIPE_POST,     // R22
                fsd_pkg::ID_SYS_TIME: c = 2'h2;
                fsd_pkg::ID_SOLICIT: c = 2'h3;                     // R9
                default: c = 2'h0;
            endcase
        end
        return c;
    endfunction : id_class

    // Two-stage capture of the serial receiver strobe and byte
    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            rx_v_m <= 1'b0;
            rx_v_s <= 1'b0;
            rx_b_m <= 8'h00;
            rx_b_s <= 8'h00;
        end else if (CLK_EN) begin
            rx_v_m <= RX_VALID;
            rx_v_s <= rx_v_m;
            rx_b_m <= RX_BYTE;
            rx_b_s <= rx_b_m;
        end
    end

    // Receive framing, dispatch and reply generation
    always_comb begin
        s_d = s_q;
        s_d.disp_v = 1'b0;
        s_d.drop = 1'b0;
        s_d.evt_rdy = 1'b0;
        pay.wr_en = 1'b0;
        pay.wr_addr = s_q.cnt[4:0];
        pay.wr_data = rx_b_s;
        pay.rd_addr = 5'h00;
        // Frames arriving while busy are ignored: the host waits for each reply
        if (rx_v_s && s_q.ex == FSD_EX_IDLE) begin
            s_d.sum = s_q.sum ^ rx_b_s;                                     // R1
            case (s_q.rx)
                FSD_RX_SYNC: begin
                    s_d.sum = rx_b_s;
                    if (rx_b_s == fsd_pkg::SYNC_BYTE) begin
                        s_d.rx = FSD_RX_LEN;                                // R1
                    end
                end
                FSD_RX_LEN: begin
                    s_d.len = rx_b_s;
                    s_d.cnt = 8'h00;
                    s_d.rx = (rx_b_s > fsd_pkg::MAX_DATA) ? FSD_RX_SYNC : FSD_RX_IDH;
                end
                FSD_RX_IDH: begin
                    s_d.id[15:8] = rx_b_s;
                    s_d.rx = FSD_RX_IDL;
                end
                FSD_RX_IDL: begin
                    s_d.id[7:0] = rx_b_s;
                    s_d.rx = (s_q.len == 8'h00) ? FSD_RX_SUM : FSD_RX_DATA;
                end
                FSD_RX_DATA: begin
                    pay.wr_en = 1'b1;
                    s_d.cnt = s_q.cnt + 8'h01;
                    if (s_q.cnt == 8'h00) begin
                        s_d.arg0 = rx_b_s;
                    end
                    if (s_q.cnt + 8'h01 == s_q.len) begin
                        s_d.rx = FSD_RX_SUM;
                    end
                end
                FSD_RX_SUM: begin
                    s_d.rx = FSD_RX_SYNC;
                    s_d.cls = id_class(s_q.id);
                    if (s_q.sum != rx_b_s || id_class(s_q.id) == 2'h0) begin
                        s_d.drop = 1'b1;                                    // R26
                    end else begin
                        s_d.ex = FSD_EX_FETCH;
                    end
                end
                default: s_d.rx = FSD_RX_SYNC;
            endcase
        end
        case (s_q.ex)
            FSD_EX_IDLE: begin
                // Events go out only between frames so replies are never interleaved
                if (EVT_VALID && s_q.rx == FSD_RX_SYNC && !rx_v_s) begin
                    s_d.evt_rdy = 1'b1;
                    s_d.tx_id = fsd_pkg::ID_EVENT_MSG;                      // R23
                    s_d.tx_code = EVT_CODE;
                    s_d.tx_idx = 3'h0;
                    s_d.ex = FSD_EX_TX;
                end
            end
            FSD_EX_FETCH: begin
                s_d.disp_v = 1'b1;
                s_d.ex = FSD_EX_BUSY;
                // Address the second payload byte early so a completion in the
                // first busy cycle already sees it on the registered read port
                pay.rd_addr = 5'h01;
                // Local copies of beacon settings the rest of the chip reads
                case (s_q.id)
                    fsd_pkg::ID_BCN_TMO: s_d.bcn_tmo = s_q.arg0;            // R25
                    fsd_pkg::ID_PAIR_TMO: s_d.pair_tmo = s_q.arg0;          // R25
                    fsd_pkg::ID_LINK_RF: s_d.link_rf = s_q.arg0;            // R21
                    fsd_pkg::ID_REM_CREATE: s_d.rem_create = s_q.arg0[0];   // R21
                    fsd_pkg::ID_BCN_OPEN: s_d.bcn_open = 1'b1;              // R24
                    fsd_pkg::ID_BCN_CLOSE: s_d.bcn_open = 1'b0;
                    default: s_d.bcn_open = s_q.bcn_open;
                endcase
            end
            FSD_EX_BUSY: begin
                // Reply only after the executing unit finishes the work
                if (DONE) begin                                              // R3 R14
                    s_d.tx_id = (s_q.cls == 2'h3) ? {s_q.arg0, pay.rd_data} : s_q.id;
                    s_d.tx_code = DONE_CODE;
                    s_d.tx_idx = 3'h0;
                    s_d.ex = FSD_EX_TX;
                end
                pay.rd_addr = 5'h01;
            end
            FSD_EX_TX: begin
                // Reply frame: sync, len 1, id high, id low, code, xor
                if (TX_READY) begin
                    s_d.tx_idx = s_q.tx_idx + 3'h1;
                    s_d.tx_sum = (s_q.tx_idx == 3'h0) ? s_q.tx_byte : s_q.tx_sum ^ s_q.tx_byte;
                    if (s_q.tx_idx == 3'h5) begin
                        s_d.ex = FSD_EX_IDLE;
                    end
                end
            end
            default: s_d.ex = FSD_EX_IDLE;
        endcase
        case (s_d.tx_idx)
            3'h0: s_d.tx_byte = fsd_pkg::SYNC_BYTE;
            3'h1: s_d.tx_byte = 8'h01;
            3'h2: s_d.tx_byte = s_d.tx_id[15:8];
            3'h3: s_d.tx_byte = s_d.tx_id[7:0];
            3'h4: s_d.tx_byte = s_d.tx_code;
            default: s_d.tx_byte = s_d.tx_sum;                               // R1
        endcase
    end

    // Single state register; clock enable freezes everything
    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            s_q <= '0;
            s_q.rx <= FSD_RX_SYNC;
            s_q.ex <= FSD_EX_IDLE;
            s_q.bcn_tmo <= fsd_pkg::BCN_TMO_DEF_S;                           // R25
            s_q.pair_tmo <= fsd_pkg::PAIR_TMO_DEF_S;                         // R25
            s_q.tx_byte <= fsd_pkg::SYNC_BYTE;
        end else if (CLK_EN) begin
            s_q <= s_d;
        end
    end

    assign DISP_VALID    = s_q.disp_v;
    assign DISP_ID       = s_q.id;
    assign DISP_CLASS    = s_q.cls;
    assign DISP_LEN      = s_q.len;
    assign DISP_ARG0     = s_q.arg0;
    assign DISP_DROP     = s_q.drop;
    assign EVT_READY     = s_q.evt_rdy;
    assign TX_VALID      = (s_q.ex == FSD_EX_TX);
    assign TX_BYTE       = s_q.tx_byte;
    assign BCN_TMO_S     = s_q.bcn_tmo;
    assign PAIR_TMO_S    = s_q.pair_tmo;
    assign LINK_RF       = s_q.link_rf;
    assign REM_CREATE_EN = s_q.rem_create;
    assign BCN_OPEN      = s_q.bcn_open;
endmodule : fsd_decoder

// ---- design/fsd_pkg.sv ----
// Behaviour
// R1: Frame: sync, length, ID, data, XOR frame_xor_byte.
// R2: Extended identifiers carry top three bits set.
// R3: EEPROM init command, then reply.
// R4: File-system init keeps saved contents.
// R5: Save open files, then reply.
// R6: Rebuild and compact directory, then reply.
// R7: Delete or close file, each replied.
// R8: Update file flags, then reply.
// R9: Requests via solicit; used space answered.
// R10: Free space request answered.
// R11: Find file index request answered.
// R12: Directory absolute read and entry read.
// R13: Directory size request answered.
// R14: Create allocates sector, stores entry, responds.
// R15: Open existing file, response returned.
// R16: Absolute and pointer file reads.
// R17: Absolute and pointer file writes.
// R18: File size and flags requests answered.
// R19: Key store, select, direct value, replied.
// R20: Pairing answer accepted/rejected, replied.
// R21: Link frequency and remote create, replied.
// R22: Command pipe fetch and post.
// R23: Events sent unsolicited as 0xE000.
// R24: Host configures beacon, then opens session.
// R25: Timeouts default 10s and 240s.
// R26: Bad frame_xor_byte or unknown ID discarded.
package fsd_pkg;
    localparam logic [7:0]  SYNC_BYTE      = 8'hA4;
    localparam logic [7:0]  EXT_PREFIX     = 8'hE0;
    localparam logic [15:0] ID_EEPROM_INIT = 16'hE220;
    localparam logic [15:0] ID_FS_INIT     = 16'hE200;
    localparam logic [15:0] ID_FORMAT      = 16'hE201;
    localparam logic [15:0] ID_DIR_SAVE    = 16'hE207;
    localparam logic [15:0] ID_DIR_COMPACT = 16'hE209;
    localparam logic [15:0] ID_FILE_DELETE = 16'hE20C;
    localparam logic [15:0] ID_FILE_CLOSE  = 16'hE20D;
    localparam logic [15:0] ID_SET_FLAGS   = 16'hE212;
    localparam logic [15:0] ID_SOLICIT     = 16'hE100;
    localparam logic [15:0] ID_USED_SPACE  = 16'hE202;
    localparam logic [15:0] ID_FREE_SPACE  = 16'hE203;
    localparam logic [15:0] ID_FIND_INDEX  = 16'hE204;
    localparam logic [15:0] ID_DIR_RD_ABS  = 16'hE205;
    localparam logic [15:0] ID_DIR_RD_ENT  = 16'hE206;
    localparam logic [15:0] ID_DIR_SIZE    = 16'hE208;
    localparam logic [15:0] ID_FILE_ALLOC  = 16'hE20A;
    localparam logic [15:0] ID_FILE_OPEN   = 16'hE20B;
    localparam logic [15:0] ID_RD_ABS      = 16'hE20E;
    localparam logic [15:0] ID_RD_PTR      = 16'hE20F;
    localparam logic [15:0] ID_WR_ABS      = 16'hE210;
    localparam logic [15:0] ID_WR_PTR      = 16'hE211;
    localparam logic [15:0] ID_FILE_SIZE   = 16'hE213;
    localparam logic [15:0] ID_FILE_FLAGS  = 16'hE214;
    localparam logic [15:0] ID_KEY_ADD     = 16'hE245;
    localparam logic [15:0] ID_KEY_SELECT  = 16'hE246;
    localparam logic [15:0] ID_KEY_DIRECT  = 16'hE247;
    localparam logic [15:0] ID_BCN_OPEN    = 16'hE231;
    localparam logic [15:0] ID_BCN_CLOSE   = 16'hE232;
    localparam logic [15:0] ID_BCN_SETUP   = 16'hE233;
    localparam logic [15:0] ID_AUTH_STR    = 16'hE234;
    localparam logic [15:0] ID_BCN_STATE   = 16'hE235;
    localparam logic [15:0] ID_PAIR_ANSWER = 16'hE236;
    localparam logic [15:0] ID_LINK_RF     = 16'hE237;
    localparam logic [15:0] ID_BCN_TMO     = 16'hE238;
    localparam logic [15:0] ID_PAIR_TMO    = 16'hE239;
    localparam logic [15:0] ID_REM_CREATE  = 16'hE23A;
    localparam logic [15:0] ID_PIPE_FETCH  = 16'hE23B;
    localparam logic [15:0] ID_PIPE_POST   = 16'hE23C;
    localparam logic [15:0] ID_SYS_TIME    = 16'hE23D;
    localparam logic [15:0] ID_EVENT_MSG   = 16'hE000;
    localparam logic [7:0]  BCN_TMO_DEF_S  = 8'h0A;   // 10 s
    localparam logic [7:0]  PAIR_TMO_DEF_S = 8'hF0;   // 240 s
    localparam logic [7:0]  MAX_DATA       = 8'h20;   // Longest accepted payload
    localparam int          PAY_DEPTH      = 32;

    // Dispatch class of an identifier; NONE when it is not recognised
    typedef enum logic [2:0] {
        FSD_CLS_NONE,
        FSD_CLS_CMD,
        FSD_CLS_REQ,
        FSD_CLS_SOLICIT
    } fsd_cls_t;
endpackage : fsd_pkg

// ---- design/fsd_pay_if.sv ----
`timescale 1ns/1ps
// Payload store port between decoder and payload memory
interface fsd_pay_if;
    logic       wr_en;
    logic [4:0] wr_addr;
    logic [7:0] wr_data;
    logic [4:0] rd_addr;
    logic [7:0] rd_data;
    modport ctl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
    modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : fsd_pay_if

// ---- design/fsd_pay_mem.sv ----
`timescale 1ns/1ps
// Payload bytes of the frame being received; registered read port
module fsd_pay_mem (
    input wire logic clk,
    input wire logic ce,
    fsd_pay_if.mem   pay
);
    logic [7:0] mem_q [fsd_pkg::PAY_DEPTH];
    logic [7:0] rd_q;

    // No reset on the array keeps it a plain RAM
    always_ff @(posedge clk) begin
        if (ce) begin
            if (pay.wr_en) begin
                mem_q[pay.wr_addr] <= pay.wr_data;
            end
            rd_q <= mem_q[pay.rd_addr];
        end
    end

    assign pay.rd_data = rd_q;
endmodule : fsd_pay_mem

// ---- bench/fsd_dec_monitor.sv ----
`timescale 1ns/1ps
// Watches the dispatch and reply ports of the decoder
module fsd_monitor (
    input wire logic        CORE_CLK,
    input wire logic        SYS_RST,
    input wire logic        DISP_VALID,
    input wire logic [15:0] DISP_ID,
    input wire logic [1:0]  DISP_CLASS,
    input wire logic        DISP_DROP,
    input wire logic        DONE,
    input wire logic        EVT_READY,
    input wire logic        TX_VALID,
    input wire logic [7:0]  TX_BYTE,
    input wire logic        TX_READY
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (SYS_RST);

    // A frame is either dispatched or dropped, never both
    AST_DISP_EXCL: assert property (!(DISP_VALID && DISP_DROP))
        else $error("frame dispatched and dropped at once");
    AST_DISP_EXT: assert property (DISP_VALID |-> DISP_ID[15:13] == 3'h7)
        else $error("dispatched id lacks extended prefix");
    AST_DISP_CLS: assert property (DISP_VALID |-> DISP_CLASS != 2'h0)
        else $error("dispatched id without a class");
    AST_DISP_PULSE: assert property (DISP_VALID |=> !DISP_VALID && !DISP_DROP)
        else $error("dispatch pulse longer than one cycle");
    AST_TX_SYNC: assert property ($rose(TX_VALID) |-> TX_BYTE == 8'hA4)
        else $error("reply does not open with sync byte");
    // A byte not yet taken must stand unchanged
    AST_TX_HOLD: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_BYTE))
        else $error("reply byte changed before it was taken");
    AST_REPLY: assert property (DONE |=> TX_VALID)
        else $error("no reply after completion");
    // The event is taken in the same edge that starts its frame from idle
    AST_EVT_IDLE: assert property (EVT_READY |-> $rose(TX_VALID) ##1 TX_VALID [*2])
        else $error("event not sent as an idle-time frame");
endmodule : fsd_monitor

bind fsd_decoder fsd_monitor u_mon (.CORE_CLK, .SYS_RST, .DISP_VALID, .DISP_ID, .DISP_CLASS,
    .DISP_DROP, .DONE, .EVT_READY, .TX_VALID, .TX_BYTE, .TX_READY);

// ---- bench/fsd_host_model.sv ----
`timescale 1ns/1ps
// Host side of the serial link: sends frames, takes reply bytes
module fsd_host_model (
    input  wire logic       CORE_CLK,
    input  wire logic       TX_VALID,
    input  wire logic [7:0] TX_BYTE,
    output logic            RX_VALID,
    output logic [7:0]      RX_BYTE,
    output logic            TX_READY
);
    logic [7:0] rx_q[$];
    logic       slow = 1'b0;
    logic       tick = 1'b0;

    initial begin
        RX_VALID = 1'b0;
        RX_BYTE = 8'h00;
        TX_READY = 1'b0;
    end

    // Slow mode stalls every other cycle so held reply bytes get exercised
    always @(posedge CORE_CLK) begin
        if (TX_VALID && TX_READY)
            rx_q.push_back(TX_BYTE);
        tick <= ~tick;
        TX_READY <= #1 (slow ? tick : 1'b1);
    end

    task automatic put_byte(input logic [7:0] b);
        @(posedge CORE_CLK);
        #1;
        RX_VALID = 1'b1;
        RX_BYTE = b;
        @(posedge CORE_CLK);
        #1;
        RX_VALID = 1'b0;
        RX_BYTE = ~b; // Released line shows no stale value
        repeat (3) @(posedge CORE_CLK);
    endtask : put_byte

    // Sync, length, id high first, data, then running XOR; corrupt spoils it
    task automatic send(input logic [15:0] id, input logic [7:0] len, input logic [7:0] d0,
                        input logic [7:0] d1, input logic corrupt);
        logic [7:0] x;
        x = 8'hA4 ^ len ^ id[15:8] ^ id[7:0];
        put_byte(8'hA4);
        put_byte(len);
        put_byte(id[15:8]);
        put_byte(id[7:0]);
        if (len > 8'h00) put_byte(d0);
        if (len > 8'h01) put_byte(d1);
        if (len > 8'h00) x = x ^ d0;
        if (len > 8'h01) x = x ^ d1;
        put_byte(corrupt ? ~x : x);
    endtask : send
endmodule : fsd_host_model

// ---- bench/test_fsd_decoder.sv ----
`timescale 1ns/1ps
module test_fsd_decoder;
    logic CORE_CLK = 1'b0, SYS_RST = 1'b1, DONE = 1'b0, EVT_VALID = 1'b0, CLK_EN = 1'b1;
    logic [7:0] DONE_CODE = 8'h00, EVT_CODE = 8'h00;
    logic RX_VALID, TX_READY, DISP_VALID, DISP_DROP, EVT_READY, TX_VALID, REM_CREATE_EN, BCN_OPEN;
    logic [7:0] RX_BYTE, DISP_LEN, DISP_ARG0, TX_BYTE, BCN_TMO_S, PAIR_TMO_S, LINK_RF;
    logic [15:0] DISP_ID;
    logic [1:0] DISP_CLASS;
    logic got_v = 1'b0, got_d = 1'b0, got_e = 1'b0;
    int fails = 0, n_tests = 0;
    logic [15:0] cmds[18] = '{16'hE220, 16'hE200, 16'hE201, 16'hE207, 16'hE209, 16'hE20C,
        16'hE20D, 16'hE212, 16'hE245, 16'hE246, 16'hE247, 16'hE233, 16'hE234, 16'hE235,
        16'hE238, 16'hE239, 16'hE237, 16'hE231};
    logic [15:0] reqs[18] = '{16'hE202, 16'hE203, 16'hE204, 16'hE205, 16'hE206, 16'hE208,
        16'hE20A, 16'hE20B, 16'hE20E, 16'hE20F, 16'hE210, 16'hE211, 16'hE213, 16'hE214,
        16'hE23B, 16'hE23C, 16'hE23D, 16'hE236};

    fsd_decoder u_dut (.CORE_CLK, .SYS_RST, .CLK_EN, .RX_VALID, .RX_BYTE, .DISP_VALID,
        .DISP_ID, .DISP_CLASS, .DISP_LEN, .DISP_ARG0, .DISP_DROP, .DONE, .DONE_CODE,
        .EVT_VALID, .EVT_CODE, .EVT_READY, .TX_VALID, .TX_BYTE, .TX_READY, .BCN_TMO_S,
        .PAIR_TMO_S, .LINK_RF, .REM_CREATE_EN, .BCN_OPEN);
    fsd_host_model u_host (.CORE_CLK, .TX_VALID, .TX_BYTE, .RX_VALID, .RX_BYTE, .TX_READY);

    initial forever #2.5 CORE_CLK = ~CORE_CLK;
    // Pulses are latched so a one-cycle strobe is never missed
    always @(posedge CORE_CLK) begin
        if (DISP_VALID === 1'b1) got_v = 1'b1;
        if (DISP_DROP === 1'b1) got_d = 1'b1;
        if (EVT_READY === 1'b1) got_e = 1'b1;
    end

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic wait_for(ref logic f);
        for (int n = 0; n < 300 && f !== 1'b1; n++) @(posedge CORE_CLK);
        #1;
        chk("wait_flag", {15'h0000, f}, 16'h0001);
    endtask : wait_for

    // Reply frame is sync, length 1, id, code, XOR of all before
    task automatic get_reply(input logic [15:0] rid, input logic [7:0] code);
        logic [7:0] e[6];
        e = '{8'hA4, 8'h01, rid[15:8], rid[7:0], code, 8'hA5 ^ rid[15:8] ^ rid[7:0] ^ code};
        for (int n = 0; n < 300 && u_host.rx_q.size() < 6; n++) @(posedge CORE_CLK);
        repeat (2) @(posedge CORE_CLK);
        #1;
        chk("reply_count", u_host.rx_q.size(), 16'h0006);
        for (int i = 0; i < 6 && u_host.rx_q.size() > 0; i++)
            chk("reply_byte", u_host.rx_q.pop_front(), e[i]);
        u_host.rx_q.delete();
    endtask : get_reply

    task automatic run(input logic [15:0] id, input logic [7:0] len, input logic [7:0] d0,
                       input logic [7:0] d1, input logic [1:0] cls, input logic [15:0] rid);
        got_v = 1'b0;
        u_host.send(id, len, d0, d1, 1'b0);
        wait_for(got_v);
        chk("disp_id", DISP_ID, id);
        chk("disp_class", DISP_CLASS, cls);
        chk("disp_len", DISP_LEN, len);
        chk("disp_arg0", DISP_ARG0, d0);
        DONE = 1'b1;
        DONE_CODE = id[7:0] ^ 8'h5A;
        @(posedge CORE_CLK);
        #1;
        DONE = 1'b0;
        DONE_CODE = 8'hFF;
        get_reply(rid, id[7:0] ^ 8'h5A);
    endtask : run

    task automatic t_commands();
        foreach (cmds[i]) begin
            u_host.slow = i[0];
            run(cmds[i], 8'h01, cmds[i][7:0], 8'h00, 2'h1, cmds[i]);
        end
        run(16'hE23A, 8'h01, 8'h01, 8'h00, 2'h1, 16'hE23A);
        chk("bcn_tmo", BCN_TMO_S, 8'h38);
        chk("pair_tmo", PAIR_TMO_S, 8'h39);
        chk("link_rf", LINK_RF, 8'h37);
        chk("rem_create", REM_CREATE_EN, 1'b1);
        chk("bcn_open", BCN_OPEN, 1'b1);
        run(16'hE232, 8'h01, 8'h32, 8'h00, 2'h1, 16'hE232);
        chk("bcn_close", BCN_OPEN, 1'b0);
    endtask : t_commands

    // Mid-run reset brings the beacon settings back to their defaults
    task automatic t_reset();
        run(16'hE23A, 8'h01, 8'h01, 8'h00, 2'h1, 16'hE23A);
        SYS_RST = 1'b1;
        repeat (3) @(posedge CORE_CLK);
        #1;
        SYS_RST = 1'b0;
        chk("bcn_tmo_rst2", BCN_TMO_S, 8'h0A);
        chk("pair_tmo_rst2", PAIR_TMO_S, 8'hF0);
        chk("cfg_rst2", {LINK_RF, REM_CREATE_EN, BCN_OPEN, TX_VALID}, 16'h0000);
    endtask : t_reset

    task automatic t_requests();
        foreach (reqs[i])
            run(reqs[i], 8'h02, 8'h11, 8'h22, i < 17 ? 2'h2 : 2'h1, reqs[i]);
        run(16'hE100, 8'h02, 8'hE2, 8'h03, 2'h3, 16'hE203);
    endtask : t_requests

    // Spoiled check byte and unknown ids are dropped with no reply
    task automatic t_discard();
        for (int k = 0; k < 3; k++) begin
            got_v = 1'b0;
            got_d = 1'b0;
            u_host.send(k == 0 ? 16'hE207 : (k == 1 ? 16'hE2FF : 16'h4D00), 8'h01, 8'h00,
                        8'h00, k == 0);
            wait_for(got_d);
            repeat (10) @(posedge CORE_CLK);
            #1;
            chk("drop", {got_d, got_v, TX_VALID}, 16'h0004);
        end
    endtask : t_discard

    task automatic t_event();
        EVT_CODE = 8'h07;
        EVT_VALID = 1'b1;
        // A low clock enable must hold the pending event back
        CLK_EN = 1'b0;
        repeat (5) @(posedge CORE_CLK);
        #1;
        chk("evt_frozen", {got_e, EVT_READY, TX_VALID}, 16'h0000);
        CLK_EN = 1'b1;
        wait_for(got_e);
        EVT_VALID = 1'b0;
        get_reply(16'hE000, 8'h07);
    endtask : t_event

    task automatic end_of_test();
        if (fails == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_of_test

    initial begin
        repeat (3) @(posedge CORE_CLK);
        #1;
        SYS_RST = 1'b0;
        chk("bcn_tmo_rst", BCN_TMO_S, 8'h0A);
        chk("pair_tmo_rst", PAIR_TMO_S, 8'hF0);
        chk("open_rst", {BCN_OPEN, TX_VALID}, 16'h0000);
        t_commands();
        t_reset();
        t_requests();
        t_discard();
        t_event();
        end_of_test();
    end

    // Whole run takes some 2000 cycles; the 40000-cycle limit means a hang
    initial begin
        #200000;
        fails++;
        end_of_test();
    end
endmodule : test_fsd_decoder
